// File: design/fail_safe_monitor.v
/*
 * Fail-safe clock monitor: watches the primary or secondary device clock
 * against a sample clock from the internal RC clock, switches to the
 * internal block on failure, restarts the watchdog and runs the start-up
 * sequence after reset.
 * Assumes ref_clk_in is the always-running internal RC clock and that the
 * watched clocks arrive as plain levels, several RC periods wide at least.
 * Limitation: a watched clock faster than half the RC rate loses edges in
 * the synchroniser. The divider, the start-up timer and the state machine
 * share this one clock, so every decision is a plain synchronous one.
 * The watchdog itself lives outside; it only sees the one-cycle clear.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fail_safe_monitor_consts.vh"

module fail_safe_monitor #(
    parameter START_EDGES = `START_TIMER_EDGES,
    parameter SAMPLE_DIV  = `SAMPLE_DIV
) (
    input  wire       ref_clk_in,
    input  wire       rstn_in,
    input  wire       monitor_enable_cfg_in,
    input  wire       watchdog_enable_in,
    input  wire       high_speed_crystal_mode_in,
    input  wire [1:0] primary_cfg_src_in,
    input  wire       primary_clk_in,
    input  wire       secondary_clk_in,
    input  wire       pm_mode_enter_in,
    input  wire [1:0] pm_mode_src_in,
    input  wire       freq_sel_wr_in,
    input  wire [2:0] freq_sel_data_in,
    input  wire       osc_fail_clr_in,
    output reg  [1:0] device_clk_sel_out,
    output reg  [7:0] osc_control_reg_out,
    output reg  [7:0] periph_irq_flags2_out,
    output reg  [2:0] internal_freq_select_out,
    output reg        fail_safe_active_out,
    output reg        watchdog_clear_out,
    output wire       internal_rc_run_out,
    output wire       sample_clk_out,
    output reg        clock_monitor_latch_out
);

    ////////////////////////////////////////////////////////////////////////
    // States

    // Start-up on the backup, run while watching, fail-safe on the backup
    localparam [1:0] ST_STARTUP  = 2'h0;
    localparam [1:0] ST_RUN      = 2'h1;
    localparam [1:0] ST_FAILSAFE = 2'h2;

    // Counter wide enough for the last edge count itself
    localparam SCW = $clog2(START_EDGES + 1);
    localparam integer START_LAST_I = START_EDGES - 1;
    localparam [SCW-1:0] START_LAST = START_LAST_I[SCW-1:0];

    reg  [1:0]     state_r;
    reg  [1:0]     state_nxt;
    reg  [1:0]     ctrl_src_r;
    reg  [1:0]     ctrl_src_nxt;
    reg            ctrl_status_r;
    reg            ctrl_status_nxt;
    reg  [SCW-1:0] start_cnt_r;
    reg            start_done_r;
    reg            fail_flag_r;
    reg  [2:0]     freq_sel_r;
    reg            watched_fall;

    wire [1:0]     clk_sync;
    wire [1:0]     clk_fall;
    wire           sample_rise;
    wire           sample_fall;
    wire           sample_level;
    wire           monitoring;
    wire           fail_detect;
    wire           primary_fall;
    genvar         gi;

    ////////////////////////////////////////////////////////////////////////
    // Clock sampling and sample clock

    // Both watched clocks enter the RC domain through two flops
    level_sync #(
        .WIDTH (2)
    ) u_clk_sync (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .async_in   ({secondary_clk_in, primary_clk_in}),
        .sync_out   (clk_sync)
    );

    sample_clock_divider #(
        .DIV (SAMPLE_DIV)
    ) u_sample_div (
        .ref_clk_in       (ref_clk_in),
        .rstn_in          (rstn_in),
        .run_in           (monitor_enable_cfg_in),
        .sample_level_out (sample_level),
        .sample_rise_out  (sample_rise),
        .sample_fall_out  (sample_fall)
    );

    assign sample_clk_out = sample_level;

    // RC stays on for the monitor whatever the watchdog does
    assign internal_rc_run_out = monitor_enable_cfg_in | watchdog_enable_in |
                                 (device_clk_sel_out == `SRC_INTERNAL);

    ////////////////////////////////////////////////////////////////////////
    // Watched clock edges

    // One falling-edge detector per watched clock
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_fall
            reg prev_r;

            // Rests low like a stopped source, so reset gives no false fall
            always @(posedge ref_clk_in or negedge rstn_in) begin
                if (!rstn_in)
                    prev_r <= 1'b0;
                else
                    prev_r <= clk_sync[gi];
            end

            assign clk_fall[gi] = prev_r & ~clk_sync[gi];
        end
    endgenerate

    assign primary_fall = clk_fall[0];

    // Only primary or secondary is ever watched
    always @* begin
        case (ctrl_src_r)
            `SRC_PRIMARY: begin
                watched_fall = clk_fall[0];
            end
            `SRC_SECONDARY: begin
                watched_fall = clk_fall[1];
            end
            default: begin
                watched_fall = 1'b0;
            end
        endcase
    end

    assign monitoring = monitor_enable_cfg_in && (state_r == ST_RUN) &&
                        (ctrl_src_r != `SRC_INTERNAL);

    ////////////////////////////////////////////////////////////////////////
    // Monitor latch and failure decision

    // Set beats clear when both land in one cycle
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            clock_monitor_latch_out <= 1'b0;
        else if (!monitoring)
            clock_monitor_latch_out <= 1'b0;
        else if (watched_fall)
            clock_monitor_latch_out <= 1'b1;
        else if (sample_rise)
            clock_monitor_latch_out <= 1'b0;
    end

    // Latch value before this edge; the rise that clears it is half a period away
    assign fail_detect = monitoring && sample_fall && clock_monitor_latch_out;

    ////////////////////////////////////////////////////////////////////////
    // Start-up timer on the primary source

    // A primary that never toggles keeps us here; only a power-managed mode leaves

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            start_cnt_r  <= {SCW{1'b0}};
            start_done_r <= 1'b0;
        end else if (state_r == ST_STARTUP && !start_done_r && primary_fall) begin
            // Crystal mode waits out the timer, other modes take the first edge
            if (!high_speed_crystal_mode_in || start_cnt_r == START_LAST)
                start_done_r <= 1'b1;
            else
                start_cnt_r <= start_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection state machine

    always @* begin
        state_nxt       = state_r;
        ctrl_src_nxt    = ctrl_src_r;
        ctrl_status_nxt = ctrl_status_r;
        case (state_r)
            ST_STARTUP: begin
                // Control word untouched until ready or a power-managed mode
                if (pm_mode_enter_in) begin
                    state_nxt    = ST_RUN;
                    ctrl_src_nxt = pm_mode_src_in;
                end else if (start_done_r) begin
                    state_nxt       = ST_RUN;
                    ctrl_src_nxt    = primary_cfg_src_in;
                    ctrl_status_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                // Power-managed entry here only reloads the source
                if (pm_mode_enter_in) begin
                    ctrl_src_nxt = pm_mode_src_in;
                end else if (fail_detect) begin
                    // Control word keeps the lost source on purpose
                    state_nxt = ST_FAILSAFE;
                end
            end
            ST_FAILSAFE: begin
                if (pm_mode_enter_in) begin
                    state_nxt    = ST_RUN;
                    ctrl_src_nxt = pm_mode_src_in;
                end
            end
            default: begin
                state_nxt = ST_STARTUP;
            end
        endcase
    end

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r       <= ST_STARTUP;
            ctrl_src_r    <= `CTRL_SRC_RESET;
            ctrl_status_r <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            ctrl_src_r    <= ctrl_src_nxt;
            ctrl_status_r <= ctrl_status_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Clock used by the core, registered to stay glitch free
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            device_clk_sel_out <= `SRC_INTERNAL;
        else if (state_nxt == ST_RUN)
            device_clk_sel_out <= ctrl_src_nxt;
        else
            device_clk_sel_out <= `SRC_INTERNAL;
    end

    // Moves on the same edge as the clock select
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            fail_safe_active_out <= 1'b0;
        else
            fail_safe_active_out <= (state_nxt == ST_FAILSAFE);
    end

    always @* begin
        osc_control_reg_out = `CTRL_RESET;
        osc_control_reg_out[`CTRL_SRC_MSB:`CTRL_SRC_LSB] = ctrl_src_r;
        osc_control_reg_out[`CTRL_STATUS_BIT] = ctrl_status_r;
    end

    // Flag is sticky; a new failure wins over a clear in the same cycle
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            fail_flag_r <= 1'b0;
        else if (fail_detect)
            fail_flag_r <= 1'b1;
        else if (osc_fail_clr_in)
            fail_flag_r <= 1'b0;
    end

    always @* begin
        periph_irq_flags2_out = `IRQ2_RESET;
        periph_irq_flags2_out[`IRQ2_FAIL_BIT] = fail_flag_r;
    end

    // One-cycle clear for watchdog counter and postscaler
    // so its timing restarts from the speed change, not before it
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            watchdog_clear_out <= 1'b0;
        else
            watchdog_clear_out <= fail_detect;
    end

    // Backup frequency field, writable at any time by software
    // Software must set it early; the block never forces a value here
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            freq_sel_r <= `FREQ_SEL_RESET;
        else if (freq_sel_wr_in)
            freq_sel_r <= freq_sel_data_in;
    end

    always @* begin
        internal_freq_select_out = freq_sel_r;
    end

endmodule

`default_nettype wire

// File: design/fail_safe_monitor_consts.vh
/*
 * Constants for the fail-safe clock monitor: source codes, control word
 * layout, reset values and the sample clock divide ratio.
 * Assumes it is included by its bare name from design files and the bench checker.
 */

`ifndef FAIL_SAFE_MONITOR_CONSTS_VH
`define FAIL_SAFE_MONITOR_CONSTS_VH

// Clock source codes
`define SRC_PRIMARY        2'h0
`define SRC_SECONDARY      2'h1
`define SRC_INTERNAL       2'h2

// Control word layout
`define CTRL_SRC_LSB       0
`define CTRL_SRC_MSB       1
`define CTRL_STATUS_BIT    3
`define CTRL_RESET         8'h00
`define CTRL_SRC_RESET     2'h0

// Second interrupt flag register
`define IRQ2_FAIL_BIT      7
`define IRQ2_RESET         8'h00

// Internal frequency select field
`define FREQ_SEL_RESET     3'h0

// Sample clock divide ratio
`define SAMPLE_DIV         64

// Start-up timer length in primary clock edges
`define START_TIMER_EDGES  1024

`endif

// File: design/level_sync.v
/*
 * Two-stage synchroniser for a group of asynchronous levels.
 * Assumes the caller reads only sync_out; the first stage has no other reader.
 */
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
    parameter WIDTH = 2
) (
    input  wire             ref_clk_in,
    input  wire             rstn_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_r;
    reg [WIDTH-1:0] stage2_r;

    // Only the second stage looks at the first
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage1_r <= {WIDTH{1'b0}};
            stage2_r <= {WIDTH{1'b0}};
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
        end
    end

    assign sync_out = stage2_r;

endmodule

`default_nettype wire

// File: design/sample_clock_divider.v
/*
 * Divides the internal RC clock into the monitor sample clock and
 * marks its rising and falling edges with one-cycle enables.
 * Assumes ref_clk_in is the internal RC clock itself.
 */
`timescale 1ns/1ns
`default_nettype none

module sample_clock_divider #(
    parameter DIV = 64
) (
    input  wire ref_clk_in,
    input  wire rstn_in,
    input  wire run_in,
    output reg  sample_level_out,
    output wire sample_rise_out,
    output wire sample_fall_out
);

    localparam CW = $clog2(DIV);
    localparam integer LAST_I = DIV - 1;
    localparam integer HALF_I = DIV / 2;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];
    localparam [CW-1:0] HALF = HALF_I[CW-1:0];

    reg [CW-1:0] count_r;
    wire [CW-1:0] count_nxt;

    assign count_nxt = (count_r == LAST) ? {CW{1'b0}} : count_r + 1'b1;

    // Rising edge at count zero, falling edge half way round
    assign sample_rise_out = run_in && (count_r == {CW{1'b0}});
    assign sample_fall_out = run_in && (count_r == HALF);

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_r          <= {CW{1'b0}};
            sample_level_out <= 1'b0;
        end else if (!run_in) begin
            count_r          <= {CW{1'b0}};
            sample_level_out <= 1'b0;
        end else begin
            count_r <= count_nxt;
            if (sample_rise_out)
                sample_level_out <= 1'b1;
            else if (sample_fall_out)
                sample_level_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: tb/ext_clock_source.sv
/* Behavioural external crystal or clock source on the far side.
   Assumes the bench starts it free running or for a counted burst. */
`timescale 1ns/1ns
`default_nettype none
module ext_clock_source #(
    parameter int HALF_NS = 160
) (
    input  wire logic       run_in,
    input  wire logic       go_in,
    input  wire logic [7:0] burst_in,
    output var  logic       clk_out
);
    int left = 0;
    always @(posedge go_in) left = burst_in;
    // A stopped source rests low, never at a stale high level
    initial begin
        clk_out = 1'h0;
        forever begin
            wait (run_in || left > 0);
            #HALF_NS clk_out = 1'h1;
            #HALF_NS clk_out = 1'h0;
            if (left > 0) left--;
        end
    end
endmodule
`default_nettype wire

// File: tb/fail_safe_check_monitor.sv
/* Concurrent checks on the fail-safe clock monitor ports.
   Assumes binding onto fail_safe_monitor; one clock, async reset. */
`timescale 1ns/1ns
`default_nettype none
`include "fail_safe_monitor_consts.vh"
module fail_safe_check #(
    parameter SAMPLE_DIV = 64
) (
    input wire logic       ref_clk_in,
    input wire logic       rstn_in,
    input wire logic       monitor_enable_cfg_in,
    input wire logic       pm_mode_enter_in,
    input wire logic       osc_fail_clr_in,
    input wire logic [1:0] device_clk_sel_out,
    input wire logic [7:0] osc_control_reg_out,
    input wire logic [7:0] periph_irq_flags2_out,
    input wire logic       fail_safe_active_out,
    input wire logic       watchdog_clear_out,
    input wire logic       internal_rc_run_out,
    input wire logic       sample_clk_out,
    input wire logic       clock_monitor_latch_out
);
    localparam int HALF = SAMPLE_DIV / 2;
    logic [7:0] hi_cnt_r;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) hi_cnt_r <= 8'h00;
        else hi_cnt_r <= sample_clk_out ? hi_cnt_r + 8'h01 : 8'h00;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////
    a_fail_effects: assert property ($rose(fail_safe_active_out) |->
        periph_irq_flags2_out[`IRQ2_FAIL_BIT] && device_clk_sel_out == `SRC_INTERNAL
        && $stable(osc_control_reg_out)) else $error("failure entry outputs wrong");
    a_wd_pulse: assert property (watchdog_clear_out |->
        $rose(fail_safe_active_out) ##1 !watchdog_clear_out) else $error("watchdog clear bad");
    a_needs_enable: assert property ($rose(fail_safe_active_out) |->
        $past(monitor_enable_cfg_in)) else $error("failure while disabled");
    a_latch_at_fall: assert property ($rose(fail_safe_active_out) |->
        $past(clock_monitor_latch_out)) else $error("failure without latch");
    a_no_rc_watch: assert property ($rose(fail_safe_active_out) |->
        $past(device_clk_sel_out) != `SRC_INTERNAL) else $error("internal clock watched");
    a_rc_kept: assert property (monitor_enable_cfg_in |-> internal_rc_run_out)
        else $error("rc stopped while enabled");
    a_sample_half: assert property ($fell(sample_clk_out) && monitor_enable_cfg_in
        && $past(monitor_enable_cfg_in) |-> hi_cnt_r == HALF) else $error("sample period");
    a_failsafe_hold: assert property (fail_safe_active_out && !pm_mode_enter_in |=>
        fail_safe_active_out) else $error("fail-safe left early");
    a_flag_sticky: assert property (periph_irq_flags2_out[7] && !osc_fail_clr_in |=>
        periph_irq_flags2_out[7]) else $error("fail flag lost");
    a_ctrl_frozen: assert property ($changed(osc_control_reg_out) |->
        $past(pm_mode_enter_in) || $rose(osc_control_reg_out[3])) else $error("ctrl moved");
    a_startup_done: assert property ($rose(osc_control_reg_out[3]) |->
        device_clk_sel_out == osc_control_reg_out[1:0]) else $error("start switch wrong");
    c_failure: cover property ($rose(fail_safe_active_out));
    c_startup: cover property ($rose(osc_control_reg_out[3]));
    c_exit: cover property ($fell(fail_safe_active_out));
endmodule
bind fail_safe_monitor fail_safe_check #(.SAMPLE_DIV(SAMPLE_DIV)) chk (.ref_clk_in,
    .rstn_in, .monitor_enable_cfg_in, .pm_mode_enter_in, .osc_fail_clr_in,
    .device_clk_sel_out, .osc_control_reg_out, .periph_irq_flags2_out, .fail_safe_active_out,
    .watchdog_clear_out, .internal_rc_run_out, .sample_clk_out, .clock_monitor_latch_out);
`default_nettype wire

// File: tb/fail_safe_monitor_tb_top.sv
/* Self-checking bench for the fail-safe clock monitor.
   Assumes two external clock models; start-up timer shortened to 4. */
`timescale 1ns/1ns
`default_nettype none
module fail_safe_monitor_tb_top;
    logic       clk, rstn, en, wde, hs, pm, fwr, clr, prun, pgo, srun;
    logic [1:0] psrc, pmsrc;
    logic [2:0] fdat;
    logic [7:0] pburst;
    wire        pclk, sclk, fs, wdc, rcr, smp, latch;
    wire  [1:0] sel;
    wire  [7:0] ctrl, irq;
    wire  [2:0] fsel;
    int         errors = 0;
    int         total_checks = 0;
    fail_safe_monitor #(.START_EDGES(4)) DUT (
        .ref_clk_in(clk), .rstn_in(rstn), .monitor_enable_cfg_in(en),
        .watchdog_enable_in(wde), .high_speed_crystal_mode_in(hs), .primary_cfg_src_in(psrc),
        .primary_clk_in(pclk), .secondary_clk_in(sclk), .pm_mode_enter_in(pm),
        .pm_mode_src_in(pmsrc), .freq_sel_wr_in(fwr), .freq_sel_data_in(fdat),
        .osc_fail_clr_in(clr), .device_clk_sel_out(sel), .osc_control_reg_out(ctrl),
        .periph_irq_flags2_out(irq), .internal_freq_select_out(fsel),
        .fail_safe_active_out(fs), .watchdog_clear_out(wdc), .internal_rc_run_out(rcr),
        .sample_clk_out(smp), .clock_monitor_latch_out(latch));
    ext_clock_source #(.HALF_NS(160)) prim (.run_in(prun), .go_in(pgo), .burst_in(pburst),
        .clk_out(pclk));
    ext_clock_source #(.HALF_NS(200)) secd (.run_in(srun), .go_in(1'h0), .burst_in(8'h00),
        .clk_out(sclk));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic checkb(input string what, input logic seen, input logic exp);
        check(what, {7'h00, seen}, {7'h00, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_fs(input int lim);
        while (fs !== 1'h1 && lim > 0) begin
            @(negedge clk);
            lim--;
        end
    endtask
    task automatic burst(input logic [7:0] n);
        @(posedge clk) pburst <= n;
        pgo <= 1'h1;
        @(posedge clk) pgo <= 1'h0;
    endtask
    task automatic pulse_pm(input logic [1:0] src);
        @(posedge clk) pm <= 1'h1;
        pmsrc <= src;
        @(posedge clk) pm <= 1'h0;
        cyc(2);
    endtask
    task automatic do_reset(input logic xtal);
        @(posedge clk) rstn <= 1'h0;
        hs <= xtal;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        cyc(1);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_startup_xtal;
        check("sel at start", {6'h00, sel}, 8'h02);
        check("ctrl at start", ctrl, 8'h00);
        burst(8'h03);
        cyc(80);
        check("ctrl short start", ctrl, 8'h00);
        check("sel short start", {6'h00, sel}, 8'h02);
        burst(8'h01);
        cyc(30);
        check("ctrl ready", ctrl, 8'h08);
        check("sel ready", {6'h00, sel}, 8'h00);
        $display("test startup_xtal done");
    endtask
    task automatic t_detect;
        @(posedge clk) prun <= 1'h1;
        cyc(300);
        checkb("failsafe while off", fs, 1'h0);
        check("irq while off", irq, 8'h00);
        @(posedge clk) en <= 1'h1;
        wait_fs(300);
        checkb("failsafe", fs, 1'h1);
        check("irq flag", irq, 8'h80);
        check("sel after fail", {6'h00, sel}, 8'h02);
        check("ctrl after fail", ctrl, 8'h08);
        checkb("watchdog clear", wdc, 1'h1);
        cyc(1);
        checkb("watchdog clear end", wdc, 1'h0);
        $display("test detect done");
    endtask
    task automatic t_exit;
        @(posedge clk) prun <= 1'h0;
        clr <= 1'h1;
        @(posedge clk) clr <= 1'h0;
        cyc(100);
        check("irq cleared", irq, 8'h00);
        checkb("failsafe held", fs, 1'h1);
        @(posedge clk) fwr <= 1'h1;
        fdat <= 3'h5;
        @(posedge clk) fwr <= 1'h0;
        cyc(1);
        check("freq select", {5'h00, fsel}, 8'h05);
        pulse_pm(2'h2);
        checkb("failsafe left", fs, 1'h0);
        check("pm source", {6'h00, ctrl[1:0]}, 8'h02);
        @(posedge clk) prun <= 1'h1;
        cyc(300);
        checkb("internal unwatched", fs, 1'h0);
        @(posedge clk) prun <= 1'h0;
        srun <= 1'h1;
        pulse_pm(2'h1);
        wait_fs(400);
        checkb("secondary fail", fs, 1'h1);
        check("ctrl keeps source", {6'h00, ctrl[1:0]}, 8'h01);
        $display("test exit done");
    endtask
    task automatic t_reset2;
        @(posedge clk) srun <= 1'h0;
        psrc <= 2'h1;
        do_reset(1'h0);
        checkb("failsafe reset", fs, 1'h0);
        check("irq reset", irq, 8'h00);
        burst(8'h02);
        cyc(30);
        check("ctrl plain start", ctrl, 8'h09);
        check("sel plain start", {6'h00, sel}, 8'h01);
        cyc(300);
        checkb("stopped clock", fs, 1'h0);
        checkb("latch idle", latch, 1'h0);
        checkb("rc with monitor", rcr, 1'h1);
        @(posedge clk) en <= 1'h0;
        cyc(1);
        checkb("rc all off", rcr, 1'h0);
        checkb("sample off", smp, 1'h0);
        @(posedge clk) wde <= 1'h1;
        cyc(1);
        checkb("rc for watchdog", rcr, 1'h1);
        $display("test reset2 done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        #150000;
        errors++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        {rstn, en, wde, hs, pm, fwr, clr, prun, pgo, srun} = 10'h000;
        {psrc, pmsrc, fdat, pburst} = 15'h0000;
        do_reset(1'h1);
        t_startup_xtal();
        t_detect();
        t_exit();
        t_reset2();
        complete_run();
    end
endmodule
`default_nettype wire
